// ---- rtl/pom_top.sv ----
// pin 3 output source mux: control register, source decode and pin driver
`timescale 1ns/1ps

module pom_top #(
  parameter int NUM_RX = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire pom_pkg::pom_rx_s      rx_status [NUM_RX],
  input  wire pom_pkg::pom_tx_s      tx_status,
  input  wire logic                  frame_sync_pulse,
  input  wire logic                  pin3_in,
  output logic                       pin3_out,
  output logic                       pin3_oe_n,
  output logic                       pin3_in_sync
);

  // ***************************************************************
  // register front end
  // ***************************************************************
  pom_pkg::pom_ctl_s pin3_output_control;
  logic              wr_pend;
  logic              rd_hit;
  logic              hreadyout_i;
  logic              hresp_i;

  pom_ahb_slave u_bus (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clk_en    (clk_en),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .wr_pend   (wr_pend),
    .rd_hit    (rd_hit),
    .hreadyout (hreadyout_i),
    .hresp     (hresp_i)
  );

  assign hreadyout = hreadyout_i;
  assign hresp     = hresp_i;

  // write lands at the end of the data phase
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pin3_output_control <= pom_pkg::CTL_RESET;
    else if (clk_en && wr_pend)
      pin3_output_control <= hwdata[pom_pkg::CTL_WIDTH-1:0];
  end

  // read data is registered at the address phase so it stands for the whole data phase;
  // a write landing on that same edge is forwarded, otherwise a read straight after a write goes stale
  logic rd_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite
                   && (hsize == pom_pkg::HSIZE_WORD) && (haddr == pom_pkg::CTL_ADDR);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (clk_en && hready)
    begin
      if (!rd_take)
        hrdata <= 32'h0000_0000;
      else if (wr_pend)
        hrdata <= {24'h00_0000, hwdata[pom_pkg::CTL_WIDTH-1:0]};
      else
        hrdata <= {24'h00_0000, pin3_output_control};
    end
  end

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  // status producers sit in other clock domains, so every level is synchronised
  localparam int RXW = $bits(pom_pkg::pom_rx_s);
  localparam int TXW = $bits(pom_pkg::pom_tx_s);
  localparam int SW  = NUM_RX * RXW + TXW + 2;

  logic [SW-1:0]     raw_in;
  logic [SW-1:0]     synced_in;
  pom_pkg::pom_rx_s  rx_s [NUM_RX];
  pom_pkg::pom_tx_s  tx_s;
  logic              fsync_s;
  logic              pin_s;

  always_comb
  begin
    raw_in = '0;
    for (int i = 0; i < NUM_RX; i++)
      raw_in[i*RXW +: RXW] = rx_status[i];
    raw_in[NUM_RX*RXW +: TXW] = tx_status;
    raw_in[SW-2] = frame_sync_pulse;
    raw_in[SW-1] = pin3_in;
  end

  pom_sync #(
    .WIDTH (SW)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clk_en  (clk_en),
    .din     (raw_in),
    .dout    (synced_in)
  );

  always_comb
  begin
    for (int i = 0; i < NUM_RX; i++)
      rx_s[i] = synced_in[i*RXW +: RXW];
    tx_s    = synced_in[NUM_RX*RXW +: TXW];
    fsync_s = synced_in[SW-2];
    pin_s   = synced_in[SW-1];
  end

  // ***************************************************************
  // source and value decode
  // ***************************************************************
  // pick one bit out of a receive port's status by value code
  function automatic logic rx_pick(input pom_pkg::pom_rx_s p, input logic [2:0] sel);
    logic r;
    r = 1'b0;
    case (sel)
      pom_pkg::RX_PIN0:  r = p.remote_pin0;
      pom_pkg::RX_PIN1:  r = p.remote_pin1;
      pom_pkg::RX_PIN3:  r = p.remote_pin3;
      pom_pkg::RX_LOCK:  r = p.lock;
      pom_pkg::RX_PASS:  r = p.pass;
      pom_pkg::RX_FRAME: r = p.frame_valid;
      pom_pkg::RX_LINE:  r = p.line_valid;
      default:           r = 1'b0;
    endcase
    return r;
  endfunction

  logic lock_or;
  logic pass_and;
  logic pass_or;
  logic any_en;
  logic next_pin;

  // with no port enabled the and-reduction reads low rather than vacuously high
  always_comb
  begin
    lock_or  = 1'b0;
    pass_and = 1'b1;
    pass_or  = 1'b0;
    any_en   = 1'b0;
    for (int i = 0; i < NUM_RX; i++)
    begin
      if (rx_s[i].port_enable)
      begin
        any_en   = 1'b1;
        lock_or  = lock_or | rx_s[i].lock;
        pass_and = pass_and & rx_s[i].pass;
        pass_or  = pass_or | rx_s[i].pass;
      end
    end
    pass_and = pass_and & any_en;
  end

  logic [2:0] src;
  logic [2:0] vsel;
  assign src  = pin3_output_control.source_select;
  assign vsel = pin3_output_control.value_select;

  always_comb
  begin
    next_pin = 1'b0;
    if (!src[2])
      next_pin = rx_pick(rx_s[src[1:0]], vsel);
    else if (src == pom_pkg::SRC_STATUS)
    begin
      case (vsel)
        pom_pkg::ST_LOCAL:      next_pin = pin3_output_control.local_value;
        pom_pkg::ST_LOCK_OR:    next_pin = lock_or;
        pom_pkg::ST_PASS_AND_A: next_pin = pass_and;
        pom_pkg::ST_PASS_AND_B: next_pin = pass_and;
        pom_pkg::ST_FSYNC:      next_pin = fsync_s;
        default:                next_pin = 1'b0;
      endcase
    end
    else if (src == pom_pkg::SRC_TX)
    begin
      case (vsel)
        pom_pkg::TX_PASS_AND:   next_pin = pass_and;
        pom_pkg::TX_PASS_OR:    next_pin = pass_or;
        pom_pkg::TX_FRAME:      next_pin = tx_s.frame_valid;
        pom_pkg::TX_LINE:       next_pin = tx_s.line_valid;
        pom_pkg::TX_SYNCED:     next_pin = tx_s.synced;
        pom_pkg::TX_IRQ:        next_pin = tx_s.tx_irq;
        default:                next_pin = 1'b0;
      endcase
    end
    else
      next_pin = 1'b0;
  end

  // ***************************************************************
  // pin driver
  // ***************************************************************
  // data is forced low while disabled so a stray enable glitch never shows stale data
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pin3_out  <= 1'b0;
      pin3_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      pin3_out  <= next_pin & pin3_output_control.drive_enable;
      pin3_oe_n <= !pin3_output_control.drive_enable;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pin3_in_sync <= 1'b0;
    else if (clk_en)
      pin3_in_sync <= pin_s;
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_oe_follows_en: assert property (
    @(posedge clk_sys) disable iff (rst)
    clk_en |=> (pin3_oe_n == !$past(pin3_output_control.drive_enable)))
    else $error("output enable does not follow bit 0");

  a_off_drives_low: assert property (
    @(posedge clk_sys) disable iff (rst)
    pin3_oe_n |-> !pin3_out)
    else $error("pin data high while undriven");

  a_local_value: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && pin3_output_control == {pom_pkg::ST_LOCAL, pom_pkg::SRC_STATUS, 2'b11})
    |=> pin3_out)
    else $error("local value not driven");

  a_reserved_src: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && (src == 3'h5 || src == 3'h7)) |=> !pin3_out)
    else $error("reserved source drives high");

  a_rx_line: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && !src[2] && vsel == pom_pkg::RX_LINE && pin3_output_control.drive_enable)
    |=> pin3_out == $past(rx_s[src[1:0]].line_valid))
    else $error("line valid not routed");

  a_tx_irq: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && src == pom_pkg::SRC_TX && vsel == pom_pkg::TX_IRQ
     && pin3_output_control.drive_enable) |=> pin3_out == $past(tx_s.tx_irq))
    else $error("tx interrupt not routed");

  a_st_reserved: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && src == pom_pkg::SRC_STATUS && vsel > pom_pkg::ST_FSYNC) |=> !pin3_out)
    else $error("reserved status code drives high");

  a_write_lands: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && wr_pend) |=> pin3_output_control == $past(hwdata[7:0]))
    else $error("register write lost");

  a_read_back: assert property (
    @(posedge clk_sys) disable iff (rst)
    rd_hit |-> hrdata == {24'h00_0000, pin3_output_control})
    else $error("read data mismatch");

  a_rx_remote0: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && !src[2] && vsel == pom_pkg::RX_PIN0 && pin3_output_control.drive_enable)
    |=> pin3_out == $past(rx_s[src[1:0]].remote_pin0))
    else $error("remote pin 0 not routed");

  a_rx_lock: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && !src[2] && vsel == pom_pkg::RX_LOCK && pin3_output_control.drive_enable)
    |=> pin3_out == $past(rx_s[src[1:0]].lock))
    else $error("port lock not routed");

  a_rx_pass: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && !src[2] && vsel == pom_pkg::RX_PASS && pin3_output_control.drive_enable)
    |=> pin3_out == $past(rx_s[src[1:0]].pass))
    else $error("port pass not routed");

  a_st_lock_or: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && src == pom_pkg::SRC_STATUS && vsel == pom_pkg::ST_LOCK_OR
     && pin3_output_control.drive_enable) |=> pin3_out == $past(lock_or))
    else $error("lock or not routed");

  a_st_fsync: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && src == pom_pkg::SRC_STATUS && vsel == pom_pkg::ST_FSYNC
     && pin3_output_control.drive_enable) |=> pin3_out == $past(fsync_s))
    else $error("frame sync not routed");

  a_tx_pass_or: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && src == pom_pkg::SRC_TX && vsel == pom_pkg::TX_PASS_OR
     && pin3_output_control.drive_enable) |=> pin3_out == $past(pass_or))
    else $error("pass or not routed");

  a_tx_frame: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && src == pom_pkg::SRC_TX && vsel == pom_pkg::TX_FRAME
     && pin3_output_control.drive_enable) |=> pin3_out == $past(tx_s.frame_valid))
    else $error("tx frame valid not routed");

  a_tx_synced: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && src == pom_pkg::SRC_TX && vsel == pom_pkg::TX_SYNCED
     && pin3_output_control.drive_enable) |=> pin3_out == $past(tx_s.synced))
    else $error("synchronized not routed");

endmodule

// ---- rtl/pom_pkg.sv ----
// package: register map, field layout and codes of the pin 3 output source mux
package pom_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  // printed offset 0x13 is not a multiple of four: it is the index, byte address is 4x
  localparam logic [7:0]  CTL_INDEX      = 8'h13;
  localparam logic [31:0] CTL_ADDR       = {22'h00_0000, CTL_INDEX, 2'b00};
  localparam logic [7:0]  CTL_RESET      = 8'h00;
  localparam int          CTL_WIDTH      = 8;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int          SEL_HI         = 7;
  localparam int          SEL_LO         = 5;
  localparam int          SRC_HI         = 4;
  localparam int          SRC_LO         = 2;
  localparam int          VAL_BIT        = 1;
  localparam int          EN_BIT         = 0;

  // ***************************************************************
  // source codes
  // ***************************************************************
  localparam logic [2:0]  SRC_STATUS     = 3'h4;
  localparam logic [2:0]  SRC_TX         = 3'h6;

  // ***************************************************************
  // value codes per source
  // ***************************************************************
  localparam logic [2:0]  RX_PIN0        = 3'h0;
  localparam logic [2:0]  RX_PIN1        = 3'h1;
  localparam logic [2:0]  RX_PIN3        = 3'h2;
  localparam logic [2:0]  RX_LOCK        = 3'h4;
  localparam logic [2:0]  RX_PASS        = 3'h5;
  localparam logic [2:0]  RX_FRAME       = 3'h6;
  localparam logic [2:0]  RX_LINE        = 3'h7;
  localparam logic [2:0]  ST_LOCAL       = 3'h0;
  localparam logic [2:0]  ST_LOCK_OR     = 3'h1;
  localparam logic [2:0]  ST_PASS_AND_A  = 3'h2;
  localparam logic [2:0]  ST_PASS_AND_B  = 3'h3;
  localparam logic [2:0]  ST_FSYNC       = 3'h4;
  localparam logic [2:0]  TX_PASS_AND    = 3'h0;
  localparam logic [2:0]  TX_PASS_OR     = 3'h1;
  localparam logic [2:0]  TX_FRAME       = 3'h2;
  localparam logic [2:0]  TX_LINE        = 3'h3;
  localparam logic [2:0]  TX_SYNCED      = 3'h4;
  localparam logic [2:0]  TX_IRQ         = 3'h5;

  // ***************************************************************
  // ahb-lite codes
  // ***************************************************************
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic [2:0] value_select;
    logic [2:0] source_select;
    logic       local_value;
    logic       drive_enable;
  } pom_ctl_s;

  // status of one receive port, all levels
  typedef struct packed {
    logic       remote_pin0;
    logic       remote_pin1;
    logic       remote_pin3;
    logic       lock;
    logic       pass;
    logic       frame_valid;
    logic       line_valid;
    logic       port_enable;
  } pom_rx_s;

  typedef struct packed {
    logic       frame_valid;
    logic       line_valid;
    logic       synced;
    logic       tx_irq;
  } pom_tx_s;

endpackage

// ---- rtl/pom_sync.sv ----
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module pom_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      dout <= '0;
    end
    else if (clk_en)
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ---- rtl/pom_ahb_slave.sv ----
// ahb-lite slave front end: captures the address phase, answers with zero wait states
`timescale 1ns/1ps
module pom_ahb_slave (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  output logic             wr_pend,
  output logic             rd_hit,
  output logic             hreadyout,
  output logic             hresp
);
  logic acc_ok;

  assign acc_ok = hsel && hready && htrans[1] && (hsize == pom_pkg::HSIZE_WORD)
                  && (haddr == pom_pkg::CTL_ADDR);

  // unmapped or odd-size accesses complete with okay and are ignored, reads return zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      rd_hit  <= 1'b0;
    end
    else if (clk_en && hready)
    begin
      wr_pend <= acc_ok && hwrite;
      rd_hit  <= acc_ok && !hwrite;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule

// ---- bench/pom_pin_partner.sv ----
// far side of pin 3: resolves the wire level and feeds it back as the pin input
`timescale 1ns/1ps
module pom_pin_partner (
  input  wire logic clk_sys,
  input  wire logic pin3_out,
  input  wire logic pin3_oe_n,
  output logic      pin_wire
);
  // ***************************************************************
  // wire resolution
  // ***************************************************************
  logic last_level = 1'b0;

  // no pull on this pin, so a released wire shows the inverse of the last driven level
  always @(posedge clk_sys)
  begin
    if (!pin3_oe_n)
      last_level <= pin3_out;
  end

  assign pin_wire = pin3_oe_n ? ~last_level : pin3_out;
endmodule

// ---- bench/tb_pom_top.sv ----
// self-checking bench for the pin 3 output source mux
`timescale 1ns/1ps
module tb_pom_top;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  logic             clk_en = 1'b1;
  logic             hsel = 1'b0;
  logic [31:0]      haddr = 32'h0000_0000;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [2:0]       hsize = 3'h0;
  logic [31:0]      hwdata = 32'h0000_0000;
  logic             hready;
  logic [31:0]      hrdata;
  logic             hreadyout;
  logic             hresp;
  pom_pkg::pom_rx_s rx_status [4];
  pom_pkg::pom_tx_s tx_status = 4'h0;
  logic             frame_sync_pulse = 1'b0;
  logic             pin_wire;
  logic             pin3_out;
  logic             pin3_oe_n;
  logic             pin3_in_sync;
  logic             rd_phase = 1'b0;
  logic             pin_chk = 1'b0;
  logic             dp_phase = 1'b0;
  logic             echo_chk = 1'b0;
  logic             resp_q [$];
  logic             echo_q [$];
  logic [1:0]       ep;
  logic [31:0]      rd_q [$];
  logic [1:0]       pin_q [$];
  int               errors = 0;
  int               tests_run = 0;
  int               seed = 20720;
  logic [31:0]      rnd;
  logic [7:0]       ctl;

  always #4 clk_sys = ~clk_sys;
  assign hready = hreadyout;

  pom_top #(.NUM_RX(4)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_status(rx_status),
    .tx_status(tx_status), .frame_sync_pulse(frame_sync_pulse), .pin3_in(pin_wire),
    .pin3_out(pin3_out), .pin3_oe_n(pin3_oe_n), .pin3_in_sync(pin3_in_sync)
  );

  pom_pin_partner i_far (
    .clk_sys(clk_sys), .pin3_out(pin3_out), .pin3_oe_n(pin3_oe_n), .pin_wire(pin_wire)
  );

  // ***************************************************************
  // reporting
  // ***************************************************************
  task automatic summarize;
    $display("comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] got);
    logic [31:0] e;
    e = 'x;
    if (rd_q.size() > 0)
      e = rd_q.pop_front();
    tests_run++;
    if (got !== e)
    begin
      errors++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic cmp_pin(input logic [1:0] got);
    logic [1:0] e;
    e = 'x;
    if (pin_q.size() > 0)
      e = pin_q.pop_front();
    tests_run++;
    if (got !== e)
    begin
      errors++;
      $display("unexpected pin at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic cmp_resp(input logic got);
    logic e;
    e = 'x;
    if (resp_q.size() > 0)
      e = resp_q.pop_front();
    tests_run++;
    if (got !== e)
    begin
      errors++;
      $display("unexpected response at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic cmp_echo(input logic got);
    logic e;
    e = 'x;
    if (echo_q.size() > 0)
      e = echo_q.pop_front();
    tests_run++;
    if (got !== e)
    begin
      errors++;
      $display("unexpected echo at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  // ***************************************************************
  // bus master and reference model
  // ***************************************************************
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                     input logic [31:0] d, input logic [31:0] exp);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= pom_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    @(posedge clk_sys);
    while (hready !== 1'b1)
      @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= ~wr;
    dp_phase <= 1'b1;
    resp_q.push_back(1'b0);
    if (!wr)
      rd_q.push_back(exp);
    @(posedge clk_sys);
    while (hready !== 1'b1)
      @(posedge clk_sys);
    rd_phase <= 1'b0;
    dp_phase <= 1'b0;
  endtask

  // returns {oe_n, out}; reserved selections drive low
  function automatic logic [1:0] exp_pin(input logic [7:0] c);
    logic             v;
    logic             anyp;
    logic             andp;
    logic             orp;
    logic             orl;
    pom_pkg::pom_rx_s p;
    v = 1'b0;
    anyp = 1'b0;
    andp = 1'b1;
    orp = 1'b0;
    orl = 1'b0;
    foreach (rx_status[k])
    begin
      if (rx_status[k].port_enable)
      begin
        anyp = 1'b1;
        andp = andp & rx_status[k].pass;
        orp = orp | rx_status[k].pass;
        orl = orl | rx_status[k].lock;
      end
    end
    andp = andp & anyp;
    p = rx_status[c[3:2]];
    if (c[4] == 1'b0)
      case (c[7:5])
        3'h0: v = p.remote_pin0;
        3'h1: v = p.remote_pin1;
        3'h2: v = p.remote_pin3;
        3'h4: v = p.lock;
        3'h5: v = p.pass;
        3'h6: v = p.frame_valid;
        3'h7: v = p.line_valid;
        default: v = 1'b0;
      endcase
    else if (c[4:2] == 3'h4)
      case (c[7:5])
        3'h0: v = c[1];
        3'h1: v = orl;
        3'h2: v = andp;
        3'h3: v = andp;
        3'h4: v = frame_sync_pulse;
        default: v = 1'b0;
      endcase
    else if (c[4:2] == 3'h6)
      case (c[7:5])
        3'h0: v = andp;
        3'h1: v = orp;
        3'h2: v = tx_status.frame_valid;
        3'h3: v = tx_status.line_valid;
        3'h4: v = tx_status.synced;
        3'h5: v = tx_status.tx_irq;
        default: v = 1'b0;
      endcase
    return c[0] ? {1'b0, v} : 2'b10;
  endfunction

  // ***************************************************************
  // monitor
  // ***************************************************************
  always @(posedge clk_sys)
  begin
    if (rd_phase && hready === 1'b1)
      cmp_rd(hrdata);
    if (pin_chk)
      cmp_pin({pin3_oe_n, pin3_out});
    if (dp_phase && hready === 1'b1)
      cmp_resp(hresp);
    if (echo_chk)
      cmp_echo(pin3_in_sync);
  end

  // ***************************************************************
  // stimulus
  // ***************************************************************
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    summarize();
  end

  initial
  begin
    foreach (rx_status[k])
      rx_status[k] = 8'h00;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    ahb(1'b0, pom_pkg::CTL_ADDR, pom_pkg::HSIZE_WORD, 32'h0, 32'h0000_0000);
    ahb(1'b1, pom_pkg::CTL_ADDR + 32'h4, pom_pkg::HSIZE_WORD, 32'h0000_00ff, 32'h0);
    ahb(1'b0, pom_pkg::CTL_ADDR + 32'h4, pom_pkg::HSIZE_WORD, 32'h0, 32'h0000_0000);
    ahb(1'b1, pom_pkg::CTL_ADDR, 3'h0, 32'h0000_00ff, 32'h0);
    // a frozen block must drop the write even though the bus still answers
    clk_en <= 1'b0;
    ahb(1'b1, pom_pkg::CTL_ADDR, pom_pkg::HSIZE_WORD, 32'h0000_00ff, 32'h0);
    clk_en <= 1'b1;
    ahb(1'b0, pom_pkg::CTL_ADDR, pom_pkg::HSIZE_WORD, 32'h0, 32'h0000_0000);
    // every control value once: all sources, all selections, enable off and on
    for (int i = 0; i < 256; i++)
    begin
      ctl = i[7:0];
      foreach (rx_status[k])
      begin
        rnd = $random(seed);
        rx_status[k] <= rnd[7:0];
      end
      rnd = $random(seed);
      tx_status <= rnd[3:0];
      frame_sync_pulse <= rnd[4];
      ahb(1'b1, pom_pkg::CTL_ADDR, pom_pkg::HSIZE_WORD, {rnd[31:8], ctl}, 32'h0);
      // inputs cross two sync flops and the pin flop, five edges leave margin
      repeat (5) @(posedge clk_sys);
      ep = exp_pin(ctl);
      pin_q.push_back(ep);
      // a driven pin comes back through the far side and three flops
      if (ctl[0])
        echo_q.push_back(ep[0]);
      pin_chk <= 1'b1;
      echo_chk <= ctl[0];
      @(posedge clk_sys);
      pin_chk <= 1'b0;
      echo_chk <= 1'b0;
      ahb(1'b0, pom_pkg::CTL_ADDR, pom_pkg::HSIZE_WORD, 32'h0, {24'h00_0000, ctl});
    end
    // a second reset in mid-run clears the register and releases the pin
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    ahb(1'b0, pom_pkg::CTL_ADDR, pom_pkg::HSIZE_WORD, 32'h0, 32'h0000_0000);
    pin_q.push_back(2'b10);
    pin_chk <= 1'b1;
    @(posedge clk_sys);
    pin_chk <= 1'b0;
    repeat (2) @(posedge clk_sys);
    summarize();
  end
endmodule
